// ==== hdl/sblm_core.sv ====
`timescale 1ns/1ps
`include "sblm_consts.svh"
// Behaviour
// - sequential reads start at low column bits, wrap inside each group of four.
// - interleaved reads deliver word index equal to start column XOR beat.
// - chopped read drives four beats, data and strobe released for the rest.
// - chopped write uses column bit 2 to pick words 0-3 or 4-7 ascending.
// - writes ignore unused column bits; eight-beat writes always ascend.
// - fixed chop, fixed eight, or per-command choice by address bit 12.
// - fixed chop starts internal write two clocks earlier.
// - per-command length keeps eight-beat write start even for chop.
// - first read data appears whole CAS latency clocks after internal read.
// - total read latency equals added latency plus CAS latency.
// - write recovery plus row precharge sets auto-precharge write delay.
// - with mask and CRC on, bad CRC blocks write, data discarded.
// - read-to-precharge plus row precharge times activation after read.
// - DLL reset bit clears itself after the reset is issued.
// - bits 20:18 select target register, code 000 is this register.
// - bits 1:0 pick length: 00 eight, 01 per command, 10 chop.
// - bit 3 selects sequential or interleaved ordering.
module sblm_core #(
  parameter int W = 8,
  parameter int LINE_BITS = 2,
  parameter int FIFO_DEPTH = 8,
  parameter logic [5:0] WRITE_START_CYC = 6'h08,
  parameter logic [5:0] ROW_PRECHARGE_CYC = 6'h0A
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_group_pins,
  input wire logic [1:0] bank_pins,
  input wire logic [17:0] addr,
  input wire logic [W-1:0] wr_word,
  input wire logic wr_word_valid,
  output logic wr_ready_r,
  input wire logic [5:0] added_command_latency,
  input wire logic data_mask_en,
  input wire logic write_crc_en,
  output logic [W-1:0] dq_out_r,
  output logic dq_oe_n_r,
  output logic dqs_out_r,
  output logic dqs_oe_n_r,
  output logic [1:0] burst_len_r,
  output logic burst_interleave_r,
  output logic vendor_test_mode_r,
  output logic dll_reset_r,
  output logic [5:0] column_read_latency_r,
  output logic [6:0] total_read_latency_r,
  output logic [4:0] write_recovery_r,
  output logic [4:0] read_to_precharge_setting_r,
  output logic write_start_r,
  output logic crc_block_r,
  output logic precharge_busy_r
);
  localparam int AW = LINE_BITS + 3;
  localparam int FAW = $clog2(FIFO_DEPTH);

  // ****************************************************************
  // functions
  // ****************************************************************
  // word index for a read beat
  function automatic logic [2:0] burst_word(input logic [2:0] col, input logic [2:0] beat,
                                            input logic ilv);
    burst_word = ilv ? (col ^ beat) : {col[2] ^ beat[2], 2'(col[1:0] + beat[1:0])};
  endfunction

  // latency code to clocks, no half clocks
  function automatic logic [5:0] cl_decode(input logic [4:0] code);
    unique case (code)
      5'h00: cl_decode = 6'h09;
      5'h01: cl_decode = 6'h0A;
      5'h02: cl_decode = 6'h0B;
      5'h03: cl_decode = 6'h0C;
      5'h04: cl_decode = 6'h0D;
      5'h05: cl_decode = 6'h0E;
      5'h06: cl_decode = 6'h0F;
      5'h07: cl_decode = 6'h10;
      5'h08: cl_decode = 6'h12;
      5'h09: cl_decode = 6'h14;
      5'h0A: cl_decode = 6'h16;
      5'h0B: cl_decode = 6'h18;
      5'h0C: cl_decode = 6'h17;
      5'h0D: cl_decode = 6'h11;
      5'h0E: cl_decode = 6'h13;
      5'h0F: cl_decode = 6'h15;
      5'h10: cl_decode = 6'h19;
      5'h11: cl_decode = 6'h1A;
      5'h13: cl_decode = 6'h1C;
      5'h14: cl_decode = 6'h1D;
      5'h15: cl_decode = 6'h1E;
      5'h16: cl_decode = 6'h1F;
      default: cl_decode = 6'h20; // reserved codes fall to the longest
    endcase
  endfunction

  // write recovery code to clocks; read-to-precharge is half of it
  function automatic logic [4:0] wr_decode(input logic [3:0] code);
    unique case (code)
      4'h0: wr_decode = 5'h0A;
      4'h1: wr_decode = 5'h0C;
      4'h2: wr_decode = 5'h0E;
      4'h3: wr_decode = 5'h10;
      4'h4: wr_decode = 5'h12;
      4'h5: wr_decode = 5'h14;
      4'h6: wr_decode = 5'h18;
      4'h7: wr_decode = 5'h16;
      4'h8: wr_decode = 5'h1A;
      default: wr_decode = 5'h1C; // reserved codes fall to the longest
    endcase
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [25:0] ca_s1_r, ca_s2_r;
  logic [W:0] wd_s1_r, wd_s2_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ca_s1_r <= '1;
      ca_s2_r <= '1;
      wd_s1_r <= '0;
      wd_s2_r <= '0;
    end else begin
      ca_s1_r <= {cs_n, ras_n, cas_n, we_n, bank_group_pins, bank_pins, addr};
      ca_s2_r <= ca_s1_r;
      wd_s1_r <= {wr_word_valid, wr_word};
      wd_s2_r <= wd_s1_r;
    end
  end

  // command decode; mode word is bank group, bank, address
  logic [21:0] mw;
  sblm_pkg::sblm_cmd_type cmd;
  logic mr_first, chop_cmd;
  assign mw = ca_s2_r[21:0];
  always_comb begin
    cmd = sblm_pkg::CMD_NOP;
    if (!ca_s2_r[25]) begin
      unique case (ca_s2_r[24:22])
        3'h0: cmd = sblm_pkg::CMD_MRS;
        3'h5: cmd = sblm_pkg::CMD_READ;
        3'h4: cmd = sblm_pkg::CMD_WRITE;
        default: cmd = sblm_pkg::CMD_NOP;
      endcase
    end
  end
  assign mr_first = (cmd == sblm_pkg::CMD_MRS) &&
                    (mw[`SBLM_SEL_HI:`SBLM_SEL_LO] == `SBLM_SEL_FIRST);
  // address bit 12 low picks the chop in per-command mode
  assign chop_cmd = (burst_len_r == `SBLM_BL_FIXED4) ||
                    ((burst_len_r == `SBLM_BL_OTF) && !mw[`SBLM_CHOP_BIT]);

  // ****************************************************************
  // mode register fields
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_len_r <= `SBLM_BL_RST;
      burst_interleave_r <= 1'b0;
      vendor_test_mode_r <= 1'b0;
      column_read_latency_r <= `SBLM_CL_RST;
      write_recovery_r <= `SBLM_WR_RST;
      read_to_precharge_setting_r <= `SBLM_RTP_RST;
    end else if (mr_first) begin
      burst_len_r <= mw[`SBLM_BL_HI:`SBLM_BL_LO];
      burst_interleave_r <= mw[`SBLM_BT_BIT];
      vendor_test_mode_r <= mw[`SBLM_TM_BIT];
      column_read_latency_r <= cl_decode({mw[12], mw[6:4], mw[2]});
      write_recovery_r <= wr_decode({mw[13], mw[11:9]});
      read_to_precharge_setting_r <= 5'(wr_decode({mw[13], mw[11:9]}) >> 1);
    end
  end

  // dll reset request is one cycle, then reads back zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dll_reset_r <= 1'b0;
    end else begin
      dll_reset_r <= mr_first && mw[`SBLM_DLLR_BIT];
    end
  end
  dll_selfclear_a: assert property (@(posedge clk) disable iff (rst)
    dll_reset_r |=> !dll_reset_r) else $error("dll reset bit did not clear");

  // overall read latency
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      total_read_latency_r <= 7'(`SBLM_CL_RST);
    end else begin
      total_read_latency_r <= 7'(added_command_latency + column_read_latency_r);
    end
  end

  // ****************************************************************
  // array
  // ****************************************************************
  logic [W-1:0] mem_r [2**AW];
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [W-1:0] mem_wdata;
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_r[mem_waddr] <= mem_wdata;
    end
  end

  // ****************************************************************
  // read engine
  // ****************************************************************
  sblm_pkg::sblm_rd_state_type rd_state_r;
  logic [2:0] rd_col_r, rd_beat_r, rd_idx_r;
  logic [LINE_BITS-1:0] rd_line_r;
  logic rd_chop_r, rd_nxt_drive;
  logic [6:0] rd_cnt_r, rd_rl_r, lat_seen_r;
  logic [2:0] rd_beat_nxt;
  assign rd_beat_nxt = (rd_state_r == sblm_pkg::RD_BURST) ? 3'(rd_beat_r + 1'b1) : 3'h0;
  assign rd_nxt_drive = !(rd_chop_r && rd_beat_nxt[2]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_state_r <= sblm_pkg::RD_IDLE;
      rd_col_r <= '0;
      rd_beat_r <= '0;
      rd_idx_r <= '0;
      rd_line_r <= '0;
      rd_chop_r <= 1'b0;
      rd_cnt_r <= '0;
      rd_rl_r <= '0;
      dq_out_r <= '0;
      dq_oe_n_r <= 1'b1;
      dqs_out_r <= 1'b0;
      dqs_oe_n_r <= 1'b1;
    end else begin
      unique case (rd_state_r)
        sblm_pkg::RD_IDLE: begin
          if (cmd == sblm_pkg::CMD_READ) begin
            rd_col_r <= mw[2:0];
            rd_line_r <= mw[AW-1:3];
            rd_chop_r <= chop_cmd;
            rd_cnt_r <= total_read_latency_r;
            rd_rl_r <= total_read_latency_r;
            rd_state_r <= sblm_pkg::RD_LAT;
          end
        end
        sblm_pkg::RD_LAT: begin
          rd_cnt_r <= 7'(rd_cnt_r - 1'b1);
          if (rd_cnt_r == 7'h01) begin
            rd_state_r <= sblm_pkg::RD_BURST;
          end
        end
        sblm_pkg::RD_BURST: begin
          if (rd_beat_r == 3'h7) begin
            rd_state_r <= sblm_pkg::RD_IDLE;
          end
        end
      endcase
      // beat outputs, loaded together with the beat index
      if ((rd_state_r == sblm_pkg::RD_LAT && rd_cnt_r == 7'h01) ||
          (rd_state_r == sblm_pkg::RD_BURST && rd_beat_r != 3'h7)) begin
        rd_beat_r <= rd_beat_nxt;
        rd_idx_r <= burst_word(rd_col_r, rd_beat_nxt, burst_interleave_r);
        dq_out_r <= mem_r[{rd_line_r, burst_word(rd_col_r, rd_beat_nxt, burst_interleave_r)}];
        dq_oe_n_r <= !rd_nxt_drive;
        dqs_oe_n_r <= !rd_nxt_drive;
        dqs_out_r <= rd_nxt_drive && !rd_beat_nxt[0];
      end else begin
        dq_oe_n_r <= 1'b1;
        dqs_oe_n_r <= 1'b1;
        dqs_out_r <= 1'b0;
      end
    end
  end

  // helper: cycles from command capture to first beat
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_seen_r <= '0;
    end else if (rd_state_r == sblm_pkg::RD_IDLE) begin
      lat_seen_r <= 7'h00;
    end else if (rd_state_r == sblm_pkg::RD_LAT) begin
      lat_seen_r <= 7'(lat_seen_r + 1'b1);
    end
  end
  read_latency_a: assert property (@(posedge clk) disable iff (rst)
    (rd_state_r == sblm_pkg::RD_BURST && rd_beat_r == 3'h0) |-> lat_seen_r == rd_rl_r)
    else $error("first read beat not at programmed latency");
  seq_order_a: assert property (@(posedge clk) disable iff (rst)
    (rd_state_r == sblm_pkg::RD_BURST && !burst_interleave_r) |->
      (rd_idx_r[2] == (rd_col_r[2] ^ rd_beat_r[2])) &&
      (2'(rd_idx_r[1:0] - rd_beat_r[1:0]) == rd_col_r[1:0]))
    else $error("sequential read order wrong");
  ilv_order_a: assert property (@(posedge clk) disable iff (rst)
    (rd_state_r == sblm_pkg::RD_BURST && burst_interleave_r) |->
      rd_idx_r == (rd_col_r ^ rd_beat_r)) else $error("interleaved read order wrong");
  chop_hiz_a: assert property (@(posedge clk) disable iff (rst)
    (rd_state_r == sblm_pkg::RD_BURST && rd_chop_r && rd_beat_r == 3'h3) |=>
      (dq_oe_n_r && dqs_oe_n_r) [*4]) else $error("chopped read drove tail beats");

  // ****************************************************************
  // write data buffer
  // ****************************************************************
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [W-1:0] fifo_out_data;
  logic [FAW:0] fifo_count;
  sblm_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH), .AW(FAW)) u_wbuf (
    .clk(clk),
    .rst(rst),
    .in_valid(wd_s2_r[W]),
    .in_ready(fifo_in_ready),
    .in_data(wd_s2_r[W-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );
  // ready leaves room for words still in the synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ready_r <= 1'b0;
    end else begin
      wr_ready_r <= fifo_in_ready &&
                    (fifo_count <= (FAW+1)'(FIFO_DEPTH - `SBLM_FIFO_MARGIN));
    end
  end

  // ****************************************************************
  // write engine
  // ****************************************************************
  sblm_pkg::sblm_wr_state_type wr_state_r;
  logic [W-1:0] stage_r [8];
  logic [W-1:0] csum_r;
  logic [3:0] wr_i_r, wr_need;
  logic [5:0] wr_cnt_r, wr_seen_r, wr_delay_r;
  logic wr_chop_r, wr_col2_r, wr_ap_r, wr_bad_r, crc_on;
  logic [LINE_BITS-1:0] wr_line_r;
  assign crc_on = data_mask_en && write_crc_en;
  assign wr_need = 4'((wr_chop_r ? `SBLM_BEATS_CHOP : `SBLM_BEATS_FULL) + crc_on);
  assign fifo_out_ready = (wr_state_r == sblm_pkg::WR_COLLECT);
  assign mem_we = (wr_state_r == sblm_pkg::WR_COMMIT) && !wr_bad_r;
  // eight-beat writes ascend from word 0; chop picks half by column bit 2
  assign mem_waddr = {wr_line_r, wr_chop_r ? {wr_col2_r, wr_i_r[1:0]} : wr_i_r[2:0]};
  assign mem_wdata = stage_r[wr_i_r[2:0]];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_state_r <= sblm_pkg::WR_IDLE;
      wr_i_r <= '0;
      wr_cnt_r <= '0;
      wr_delay_r <= '0;
      wr_chop_r <= 1'b0;
      wr_col2_r <= 1'b0;
      wr_ap_r <= 1'b0;
      wr_bad_r <= 1'b0;
      wr_line_r <= '0;
      csum_r <= '0;
      write_start_r <= 1'b0;
      crc_block_r <= 1'b0;
    end else begin
      write_start_r <= 1'b0;
      crc_block_r <= 1'b0;
      unique case (wr_state_r)
        sblm_pkg::WR_IDLE: begin
          if (cmd == sblm_pkg::CMD_WRITE) begin
            wr_chop_r <= chop_cmd;
            wr_col2_r <= mw[`SBLM_COL2_BIT];
            wr_line_r <= mw[AW-1:3];
            wr_ap_r <= mw[`SBLM_AP_BIT];
            // only the fixed chop mode pulls the internal start in
            wr_cnt_r <= (burst_len_r == `SBLM_BL_FIXED4) ?
                        6'(WRITE_START_CYC - `SBLM_CHOP_ADVANCE) : WRITE_START_CYC;
            wr_delay_r <= (burst_len_r == `SBLM_BL_FIXED4) ?
                          6'(WRITE_START_CYC - `SBLM_CHOP_ADVANCE) : WRITE_START_CYC;
            wr_state_r <= sblm_pkg::WR_WAIT;
          end
        end
        sblm_pkg::WR_WAIT: begin
          wr_cnt_r <= 6'(wr_cnt_r - 1'b1);
          if (wr_cnt_r == 6'h01) begin
            write_start_r <= 1'b1; // recovery reference point
            wr_i_r <= '0;
            csum_r <= '0;
            wr_state_r <= sblm_pkg::WR_COLLECT;
          end
        end
        sblm_pkg::WR_COLLECT: begin
          if (fifo_out_valid) begin
            wr_i_r <= 4'(wr_i_r + 1'b1);
            if (wr_i_r == 4'(wr_need - 1'b1)) begin
              // checksum word follows the data when checking is on
              wr_bad_r <= crc_on && (csum_r != fifo_out_data);
              crc_block_r <= crc_on && (csum_r != fifo_out_data);
              wr_i_r <= '0;
              wr_state_r <= sblm_pkg::WR_COMMIT;
            end else begin
              csum_r <= csum_r ^ fifo_out_data;
            end
          end
        end
        sblm_pkg::WR_COMMIT: begin
          wr_i_r <= 4'(wr_i_r + 1'b1);
          if (wr_i_r == 4'((wr_chop_r ? `SBLM_BEATS_CHOP : `SBLM_BEATS_FULL) - 1'b1)) begin
            wr_bad_r <= 1'b0;
            wr_state_r <= sblm_pkg::WR_IDLE;
          end
        end
      endcase
    end
  end

  // staging keeps data out of the array until checked
  always_ff @(posedge clk) begin
    if (wr_state_r == sblm_pkg::WR_COLLECT && fifo_out_valid && !wr_i_r[3]) begin
      stage_r[wr_i_r[2:0]] <= fifo_out_data;
    end
  end

  // helper: cycles from write capture to start pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_seen_r <= '0;
    end else if (wr_state_r == sblm_pkg::WR_IDLE) begin
      wr_seen_r <= 6'h01;
    end else if (wr_state_r == sblm_pkg::WR_WAIT) begin
      wr_seen_r <= 6'(wr_seen_r + 1'b1);
    end
  end
  write_start_a: assert property (@(posedge clk) disable iff (rst)
    write_start_r |-> (wr_seen_r == 6'(wr_delay_r + 1'b1)) &&
      (wr_delay_r == ((burst_len_r == `SBLM_BL_FIXED4) ?
                     6'(WRITE_START_CYC - `SBLM_CHOP_ADVANCE) : WRITE_START_CYC)))
    else $error("internal write start at wrong point");
  crc_block_a: assert property (@(posedge clk) disable iff (rst)
    crc_block_r |-> !mem_we [*8]) else $error("blocked write reached the array");
  write_order_a: assert property (@(posedge clk) disable iff (rst)
    (mem_we && !wr_chop_r) |-> mem_waddr[2:0] == wr_i_r[2:0])
    else $error("eight-beat write not ascending");

  // ****************************************************************
  // auto precharge timing
  // ****************************************************************
  logic [6:0] pre_cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt_r <= '0;
      precharge_busy_r <= 1'b0;
    end else begin
      if (cmd == sblm_pkg::CMD_READ && rd_state_r == sblm_pkg::RD_IDLE && mw[`SBLM_AP_BIT]) begin
        pre_cnt_r <= 7'(read_to_precharge_setting_r + ROW_PRECHARGE_CYC);
      end else if (write_start_r && wr_ap_r) begin
        pre_cnt_r <= 7'(write_recovery_r + ROW_PRECHARGE_CYC);
      end else if (pre_cnt_r != '0) begin
        pre_cnt_r <= 7'(pre_cnt_r - 1'b1);
      end
      precharge_busy_r <= (pre_cnt_r > 7'h01);
    end
  end
  mode_load_a: assert property (@(posedge clk) disable iff (rst)
    mr_first |=> burst_len_r == $past(mw[1:0])) else $error("length field not loaded");
endmodule // sblm_core

// ==== hdl/sblm_consts.svh ====
`ifndef SBLM_CONSTS_SVH
`define SBLM_CONSTS_SVH
// ****************************************************************
// mode word field positions (bank group 21:20, bank 19:18, address 17:0)
// ****************************************************************
`define SBLM_SEL_HI 20
`define SBLM_SEL_LO 18
`define SBLM_BL_HI 1
`define SBLM_BL_LO 0
`define SBLM_BT_BIT 3
`define SBLM_TM_BIT 7
`define SBLM_DLLR_BIT 8
`define SBLM_AP_BIT 10
`define SBLM_CHOP_BIT 12
`define SBLM_COL2_BIT 2
// ****************************************************************
// encodings
// ****************************************************************
`define SBLM_SEL_FIRST 3'h0
`define SBLM_BL_FIXED8 2'h0
`define SBLM_BL_OTF 2'h1
`define SBLM_BL_FIXED4 2'h2
// ****************************************************************
// reset values and counts
// ****************************************************************
`define SBLM_BL_RST 2'h0
`define SBLM_CL_RST 6'h09
`define SBLM_WR_RST 5'h0A
`define SBLM_RTP_RST 5'h05
`define SBLM_CHOP_ADVANCE 6'h02
`define SBLM_BEATS_FULL 4'h8
`define SBLM_BEATS_CHOP 4'h4
`define SBLM_FIFO_MARGIN 4'h3
`endif

// ==== hdl/sblm_pkg.sv ====
// ****************************************************************
// shared types
// ****************************************************************
package sblm_pkg;
  typedef enum logic [1:0] {CMD_NOP, CMD_MRS, CMD_READ, CMD_WRITE} sblm_cmd_type;
  typedef enum logic [1:0] {RD_IDLE, RD_LAT, RD_BURST} sblm_rd_state_type;
  typedef enum logic [1:0] {WR_IDLE, WR_WAIT, WR_COLLECT, WR_COMMIT} sblm_wr_state_type;
endpackage

// ==== hdl/sblm_fifo.sv ====
`timescale 1ns/1ps
// ****************************************************************
// write data buffer, flip-flop storage
// ****************************************************************
module sblm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] count
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;

  // handshakes and honest flags
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rp_r];
  assign count = cnt_r;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : AW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : AW'(rp_r + 1'b1);
      end
      cnt_r <= (AW+1)'(cnt_r + push - pop);
    end
  end
endmodule // sblm_fifo

// ==== verif/sblm_ctrl_model.sv ====
`timescale 1ns/1ps
// ****
// controller side
// ****
module sblm_ctrl_model (
  input wire logic clk,
  input wire logic wr_ready_r,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [21:0] word,
  output logic [7:0] wr_word,
  output logic wr_word_valid
);
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    word = 22'h000000;
    wr_word = 8'h00;
    wr_word_valid = 1'b0;
  end
  // one command for one cycle, mode word on bank and address lines
  task automatic cmd(input logic [2:0] rcw, input logic [21:0] w);
    @(posedge clk) #2;
    {cs_n, ras_n, cas_n, we_n} = {1'b0, rcw};
    word = w; // callers keep bit 7 zero and legal codes
    @(posedge clk) #2;
    cs_n = 1'b1;
    word = ~w; // released lines do not hold
  endtask
  // words one per cycle, paused while room is short
  task automatic send(input logic [7:0] base, input int n, output bit ok);
    int i;
    int t;
    i = 0;
    t = 0;
    while (i < n && t < 200) begin
      @(posedge clk) #2;
      t++;
      wr_word_valid = wr_ready_r;
      wr_word = wr_ready_r ? base + i[7:0] : ~wr_word;
      if (wr_ready_r) i++;
    end
    @(posedge clk) #2;
    wr_word_valid = 1'b0;
    wr_word = ~wr_word;
    ok = (i == n);
  endtask
endmodule // sblm_ctrl_model

// ==== verif/sdram_burst_latency_mode_control_tb.sv ====
`timescale 1ns/1ps
// ****
// bench
// ****
module sdram_burst_latency_mode_control_tb;
  logic clk, rst, cs_n, ras_n, cas_n, we_n, wv, rdy, dq_oe_n, dqs_oe_n, dll, ws, ilv;
  logic [1:0] bl;
  logic [21:0] word;
  logic [7:0] wd, dq;
  logic [5:0] al;
  logic [6:0] rl;
  logic [4:0] wrr, read_to_precharge_setting;
  logic [5:0] cl;
  logic tm, cb, pb, crc, dqs;
  logic [7:0] mem [8];
  int errors, samples_checked;
  sblm_ctrl_model m (.clk(clk), .wr_ready_r(rdy), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .word(word), .wr_word(wd), .wr_word_valid(wv));
  sblm_core uut (.clk(clk), .rst(rst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_group_pins(word[21:20]), .bank_pins(word[19:18]), .addr(word[17:0]), .wr_word(wd),
    .wr_word_valid(wv), .wr_ready_r(rdy), .added_command_latency(al), .data_mask_en(crc),
    .write_crc_en(crc), .dq_out_r(dq), .dq_oe_n_r(dq_oe_n), .dqs_out_r(dqs),
    .dqs_oe_n_r(dqs_oe_n), .burst_len_r(bl), .burst_interleave_r(ilv),
    .vendor_test_mode_r(tm), .dll_reset_r(dll), .column_read_latency_r(cl),
    .total_read_latency_r(rl), .write_recovery_r(wrr), .read_to_precharge_setting_r(read_to_precharge_setting),
    .write_start_r(ws), .crc_block_r(cb), .precharge_busy_r(pb));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic setmode(input logic [21:0] w);
    m.cmd(3'h0, w);
    repeat (4) @(posedge clk);
  endtask
  task automatic t_mode;
    chk("wr", 8'h0A, {3'h0, wrr});
    chk("rtp", 8'h05, {3'h0, read_to_precharge_setting});
    chk("rl", 8'h09, {1'h0, rl});
    setmode(22'h04010A);
    chk("sel", 8'h00, {6'h0, bl});
    m.cmd(3'h0, 22'h00031A);
    repeat (2) @(posedge clk);
    #1 chk("dll", 8'h01, {7'h0, dll});
    chk("bl", 8'h02, {6'h0, bl});
    chk("bt", 8'h01, {7'h0, ilv});
    chk("cl", 8'h0B, {2'h0, cl});
    chk("wr code", 8'h0C, {3'h0, wrr});
    chk("rtp code", 8'h06, {3'h0, read_to_precharge_setting});
    chk("tm", 8'h00, {7'h0, tm});
    @(posedge clk) #1 chk("dll clr", 8'h00, {7'h0, dll});
    chk("rl code", 8'h0B, {1'h0, rl});
  endtask
  // bad checksum word with auto precharge: write dropped, timer still runs
  task automatic t_crc;
    int c;
    bit ok;
    c = 0;
    #2 crc = 1'b1;
    m.cmd(3'h4, 22'h000400);
    fork
      m.send(8'hD0, 5, ok);
      while (cb !== 1'b1 && c < 40) begin
        @(posedge clk) #1;
        c++;
      end
    join
    chk("crc block", 8'h01, {7'h0, cb});
    chk("ap busy", 8'h01, {7'h0, pb});
    chk("crc sent", 8'h01, {7'h0, ok});
    repeat (30) @(posedge clk);
    #2 crc = 1'b0;
    chk("ap done", 8'h00, {7'h0, pb});
  endtask
  task automatic wr(input logic [21:0] w, input logic [7:0] base, input int n, input int s);
    int c;
    bit ok;
    c = 0;
    m.cmd(3'h4, w);
    fork
      m.send(base, n, ok);
      while (ws !== 1'b1 && c < 40) begin
        @(posedge clk) #1;
        c++;
      end
    join
    chk("start", s[7:0], c[7:0]);
    chk("sent", 8'h01, {7'h0, ok});
    repeat (30) @(posedge clk);
    for (int i = 0; i < n; i++) mem[(n == 4) ? {w[2], i[1:0]} : i[2:0]] = base + i[7:0];
  endtask
  task automatic rd(input logic [2:0] c, input logic il, input logic ch, input int r,
    input logic a12);
    logic [2:0] x;
    m.cmd(3'h5, {9'h0, a12, 9'h0, c});
    repeat (2 + r) @(posedge clk);
    for (int b = 0; b < 8; b++) begin
      #1;
      x = il ? c ^ b[2:0] : {c[2] ^ b[2], c[1:0] + b[1:0]};
      if (ch && b > 3) chk("oe off", 8'h03, {6'h0, dq_oe_n, dqs_oe_n});
      else begin
        chk("beat", mem[x], dq_oe_n ? 8'hXX : dq);
        chk("dqs", {7'h0, ~b[0]}, {6'h0, dqs_oe_n, dqs});
      end
      @(posedge clk);
    end
    #1 chk("oe end", 8'h03, {6'h0, dq_oe_n, dqs_oe_n});
    repeat (12) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    rst = 1'b1;
    al = 6'h00;
    crc = 1'b0;
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    t_mode();
    setmode(22'h000000);
    wr(22'h000007, 8'hA0, 8, 10);
    setmode(22'h000002);
    wr(22'h000004, 8'hB0, 4, 8);
    rd(3'h5, 1'b0, 1'b1, 9, 1'b0);
    setmode(22'h000009);
    wr(22'h000000, 8'hC0, 4, 10);
    t_crc();
    #2 al = 6'h02;
    rd(3'h3, 1'b1, 1'b0, 11, 1'b1);
    rd(3'h6, 1'b1, 1'b1, 11, 1'b0);
    report_and_stop();
  end
endmodule // sdram_burst_latency_mode_control_tb
